// [logic/ccs_pkg.sv]
// Package with register map, field positions, reset values and types of the compass command block.
package ccs_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DEPTH = 8'h04;
    localparam logic [7:0] ADDR_CLIP = 8'h08;
    localparam logic [7:0] ADDR_DECL = 8'h0c;
    localparam logic [7:0] ADDR_PERIOD = 8'h10;
    localparam logic [7:0] ADDR_SCORE = 8'h14;
    localparam logic [7:0] ADDR_HEADING = 8'h18;
    localparam logic [7:0] ADDR_TILT = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_MASK = 8'h24;

    localparam int CTRL_DAMP_BIT = 0;
    localparam int CTRL_NORTH_BIT = 1;
    localparam int CTRL_UNITS_BIT = 2;
    localparam int CTRL_CAL_BIT = 3;
    localparam int CTRL_ORDER_BIT = 4;
    localparam int CTRL_SAVE_BIT = 5;
    localparam int TILT_FLAG_BIT = 16;

    localparam int ST_CLIP = 0;
    localparam int ST_CAL_DONE = 1;
    localparam int ST_SAVE_DONE = 2;
    localparam int ST_REJECT = 3;
    localparam int ST_W = 4;

    localparam logic [3:0] DEPTH_RESET = 4'h1;
    localparam logic [3:0] DEPTH_MIN = 4'h1;
    localparam logic [3:0] DEPTH_MAX = 4'h8;
    localparam logic [15:0] CLIP_RESET = 16'h0000;
    localparam logic signed [15:0] DECL_RESET = 16'sh0000;
    localparam logic signed [15:0] DECL_DEG_MAX = 16'sh00b4;
    localparam logic signed [15:0] DECL_MIL_MAX = 16'sh0c80;
    localparam logic signed [17:0] CIRCLE_DEG = 18'sh00168;
    localparam logic signed [17:0] CIRCLE_MIL = 18'sh01900;
    localparam logic ORDER_RESET = 1'b1;
    localparam logic [2:0] PERIOD_RESET = 3'h0;
    localparam logic [3:0] SCORE_CAP = 4'h9;
    localparam int SCORE_SHIFT = 4;
    localparam logic [15:0] MAG_MIN = 16'h0001;

    typedef struct packed {
        logic damp_en;
        logic north_true;
        logic units_mils;
        logic cal_en;
        logic order_big;
        logic [3:0] depth;
        logic [15:0] clip;
        logic signed [15:0] decl;
        logic [2:0] period;
    } ccs_cfg_t;

    typedef struct packed {
        logic [3:0] h;
        logic [3:0] v;
        logic [15:0] m;
    } ccs_score_t;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_COLLECT = 3'b010,
        CAL_SCORE = 3'b100
    } ccs_cal_state_t;
endpackage

// [logic/ccs_top.sv]
// Compass settings, heading correction and calibration engine behind an APB slave.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module ccs_top #(
    parameter logic [15:0] TILT_MAX = 16'h0384,
    parameter logic [2:0] PERIOD_MAX = 3'h7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [15:0] heading_raw,
    input wire logic signed [15:0] tilt_raw,
    input wire logic signed [15:0] mag_x,
    input wire logic signed [15:0] mag_y,
    input wire logic module_has_cpu,
    input wire logic [31:0] host_tx_word,
    output logic [31:0] mod_tx_word,
    input wire logic [31:0] mod_rx_word,
    output logic [31:0] host_param_word,
    output logic [15:0] heading_out,
    output logic heading_valid,
    output logic signed [15:0] tilt_out,
    output logic tilt_clipped,
    output logic [2:0] conversion_period_select,
    output ccs_pkg::ccs_cfg_t settings,
    output logic signed [15:0] cal_off_x,
    output logic signed [15:0] cal_off_y,
    output logic cal_active,
    output logic save_req,
    input wire logic save_ack,
    output logic irq
);
    ccs_pkg::ccs_cfg_t cfg;
    ccs_pkg::ccs_score_t score;
    ccs_pkg::ccs_cal_state_t cal_state;
    logic [ccs_pkg::ST_W-1:0] status;
    logic [ccs_pkg::ST_W-1:0] mask;
    logic [ccs_pkg::ST_W-1:0] ev_set;
    logic wr;
    logic ev_reject;
    logic ev_clip;
    logic ev_cal_done;
    logic s1_valid;
    logic [15:0] s1_heading;
    logic signed [23:0] damp_acc;
    logic signed [17:0] corr_sum;
    logic signed [17:0] circle;
    logic signed [24:0] damp_diff;
    logic signed [15:0] min_x;
    logic signed [15:0] max_x;
    logic signed [15:0] min_y;
    logic signed [15:0] max_y;
    logic [15:0] tilt_peak;
    logic [15:0] tilt_abs;
    logic cal_first;
    logic [16:0] span_x;
    logic [16:0] span_y;
    logic [16:0] span_sum;
    logic [16:0] span_diff;

    function automatic logic decl_ok(input logic signed [15:0] v, input logic mils);
        logic signed [15:0] lim;
        lim = mils ? ccs_pkg::DECL_MIL_MAX : ccs_pkg::DECL_DEG_MAX;
        decl_ok = (v <= lim) && (v >= -lim);
    endfunction

    function automatic logic [3:0] cap_score(input logic [16:0] v);
        logic [16:0] s;
        s = v >> ccs_pkg::SCORE_SHIFT;
        cap_score = (s > 17'(ccs_pkg::SCORE_CAP)) ? ccs_pkg::SCORE_CAP : s[3:0];
    endfunction

    function automatic logic [31:0] swap32(input logic [31:0] w);
        swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= ccs_pkg::ADDR_MASK);
    endfunction

    // Zero wait state slave; unmapped words answer with an error.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr = psel && penable && pwrite && is_mapped(paddr);
    assign settings = cfg;
    assign conversion_period_select = cfg.period;
    assign cal_active = cfg.cal_en;
    assign irq = |(status & mask);

    // Settings writes; depth, clip, declination and period are range checked before they land, control bits are not.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.damp_en <= 1'b0;
            cfg.north_true <= 1'b0;
            cfg.units_mils <= 1'b0;
            cfg.cal_en <= 1'b0;
            cfg.order_big <= ccs_pkg::ORDER_RESET;
            cfg.depth <= ccs_pkg::DEPTH_RESET;
            cfg.clip <= ccs_pkg::CLIP_RESET;
            cfg.decl <= ccs_pkg::DECL_RESET;
            cfg.period <= ccs_pkg::PERIOD_RESET;
            ev_reject <= 1'b0;
        end else begin
            ev_reject <= 1'b0;
            if (wr) begin
                case (paddr)
                    ccs_pkg::ADDR_CTRL: begin
                        cfg.damp_en <= pwdata[ccs_pkg::CTRL_DAMP_BIT];
                        cfg.north_true <= pwdata[ccs_pkg::CTRL_NORTH_BIT];
                        cfg.units_mils <= pwdata[ccs_pkg::CTRL_UNITS_BIT];
                        cfg.cal_en <= pwdata[ccs_pkg::CTRL_CAL_BIT];
                        cfg.order_big <= pwdata[ccs_pkg::CTRL_ORDER_BIT];
                    end
                    ccs_pkg::ADDR_DEPTH: begin
                        if (pwdata[31:4] == 28'h0 && pwdata[3:0] >= ccs_pkg::DEPTH_MIN &&
                            pwdata[3:0] <= ccs_pkg::DEPTH_MAX) begin
                            cfg.depth <= pwdata[3:0];
                        end else begin
                            ev_reject <= 1'b1;
                        end
                    end
                    ccs_pkg::ADDR_CLIP: begin
                        if (pwdata[31:16] == 16'h0 && pwdata[15:0] <= TILT_MAX) begin
                            cfg.clip <= pwdata[15:0];
                        end else begin
                            ev_reject <= 1'b1;
                        end
                    end
                    ccs_pkg::ADDR_DECL: begin
                        if (decl_ok(pwdata[15:0], cfg.units_mils)) begin
                            cfg.decl <= pwdata[15:0];
                        end else begin
                            ev_reject <= 1'b1;
                        end
                    end
                    ccs_pkg::ADDR_PERIOD: begin
                        if (pwdata[31:3] == 29'h0 && pwdata[2:0] <= PERIOD_MAX) begin
                            cfg.period <= pwdata[2:0];
                        end else begin
                            ev_reject <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Save request stays up until the storage side acknowledges it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_req <= 1'b0;
        end else if (save_req && save_ack) begin
            save_req <= 1'b0;
        end else if (wr && paddr == ccs_pkg::ADDR_CTRL && pwdata[ccs_pkg::CTRL_SAVE_BIT]) begin
            save_req <= 1'b1;
        end
    end

    // Read data is captured in the setup cycle so it stands in a flip-flop for the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ccs_pkg::ADDR_CTRL: prdata <= {26'h0, save_req, cfg.order_big, cfg.cal_en,
                                               cfg.units_mils, cfg.north_true, cfg.damp_en};
                ccs_pkg::ADDR_DEPTH: prdata <= {28'h0, cfg.depth};
                ccs_pkg::ADDR_CLIP: prdata <= {16'h0, cfg.clip};
                ccs_pkg::ADDR_DECL: prdata <= {{16{cfg.decl[15]}}, cfg.decl};
                ccs_pkg::ADDR_PERIOD: prdata <= {29'h0, cfg.period};
                ccs_pkg::ADDR_SCORE: prdata <= {8'h0, score};
                ccs_pkg::ADDR_HEADING: prdata <= {16'h0, heading_out};
                ccs_pkg::ADDR_TILT: prdata <= {15'h0, tilt_clipped, tilt_out};
                ccs_pkg::ADDR_STATUS: prdata <= {28'h0, status};
                ccs_pkg::ADDR_MASK: prdata <= {28'h0, mask};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Sticky status, cleared by writing ones; a new event in the same cycle wins.
    assign ev_set = {ev_reject, save_req & save_ack, ev_cal_done, ev_clip};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            mask <= '0;
        end else begin
            if (wr && paddr == ccs_pkg::ADDR_STATUS) begin
                status <= (status & ~pwdata[ccs_pkg::ST_W-1:0]) | ev_set;
            end else begin
                status <= status | ev_set;
            end
            if (wr && paddr == ccs_pkg::ADDR_MASK) begin
                mask <= pwdata[ccs_pkg::ST_W-1:0];
            end
        end
    end

    // Heading correction when the module has no CPU: declination, wrapped into one full circle of the chosen unit.
    assign circle = cfg.units_mils ? ccs_pkg::CIRCLE_MIL : ccs_pkg::CIRCLE_DEG;
    assign corr_sum = $signed({2'b00, heading_raw}) +
                      (cfg.north_true ? 18'(cfg.decl) : 18'sh00000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_valid <= 1'b0;
            s1_heading <= 16'h0;
        end else begin
            s1_valid <= sample_valid;
            if (sample_valid) begin
                if (module_has_cpu) begin
                    s1_heading <= heading_raw;
                end else if (corr_sum < 18'sh00000) begin
                    s1_heading <= 16'(corr_sum + circle);
                end else if (corr_sum >= circle) begin
                    s1_heading <= 16'(corr_sum - circle);
                end else begin
                    s1_heading <= corr_sum[15:0];
                end
            end
        end
    end

    // Exponential damping with weight 2^-(depth-1), skipped when the module has a CPU; it ignores the wrap at north, so
    // headings near the wrap point settle through the long way round.
    assign damp_diff = $signed({1'b0, s1_heading, 8'h00}) - 25'(damp_acc);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            damp_acc <= 24'sh000000;
            heading_out <= 16'h0;
            heading_valid <= 1'b0;
        end else begin
            heading_valid <= s1_valid;
            if (s1_valid) begin
                if (cfg.damp_en && !module_has_cpu) begin
                    damp_acc <= damp_acc + 24'(damp_diff >>> (cfg.depth - 4'h1));
                    heading_out <= 16'((damp_acc + 24'(damp_diff >>> (cfg.depth - 4'h1))) >>> 8);
                end else begin
                    damp_acc <= $signed({s1_heading, 8'h00});
                    heading_out <= s1_heading;
                end
            end
        end
    end

    // Tilt clipping against the stored limit in both directions.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tilt_out <= 16'sh0000;
            tilt_clipped <= 1'b0;
            ev_clip <= 1'b0;
        end else begin
            ev_clip <= 1'b0;
            if (sample_valid) begin
                if (tilt_raw > $signed(cfg.clip)) begin
                    tilt_out <= $signed(cfg.clip);
                    tilt_clipped <= 1'b1;
                    ev_clip <= 1'b1;
                end else if (tilt_raw < -$signed(cfg.clip)) begin
                    tilt_out <= -$signed(cfg.clip);
                    tilt_clipped <= 1'b1;
                    ev_clip <= 1'b1;
                end else begin
                    tilt_out <= tilt_raw;
                    tilt_clipped <= 1'b0;
                end
            end
        end
    end

    // Word order toward and from the module.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_tx_word <= 32'h0;
            host_param_word <= 32'h0;
        end else if (module_has_cpu && !cfg.order_big) begin
            mod_tx_word <= swap32(host_tx_word);
            host_param_word <= swap32(mod_rx_word);
        end else begin
            mod_tx_word <= host_tx_word;
            host_param_word <= mod_rx_word;
        end
    end

    // Calibration: track field extremes while enabled, score them when disabled.
    assign tilt_abs = tilt_raw[15] ? 16'(-tilt_raw) : tilt_raw;
    assign span_x = 17'($signed({max_x[15], max_x}) - $signed({min_x[15], min_x}));
    assign span_y = 17'($signed({max_y[15], max_y}) - $signed({min_y[15], min_y}));
    assign span_sum = span_x + span_y;
    assign span_diff = (span_x > span_y) ? span_x - span_y : span_y - span_x;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state <= ccs_pkg::CAL_IDLE;
            cal_first <= 1'b0;
            ev_cal_done <= 1'b0;
            min_x <= 16'sh0000;
            max_x <= 16'sh0000;
            min_y <= 16'sh0000;
            max_y <= 16'sh0000;
            tilt_peak <= 16'h0;
            cal_off_x <= 16'sh0000;
            cal_off_y <= 16'sh0000;
            score <= '{h: 4'h0, v: 4'h0, m: ccs_pkg::MAG_MIN};
        end else begin
            ev_cal_done <= 1'b0;
            case (cal_state)
                ccs_pkg::CAL_IDLE: begin
                    if (cfg.cal_en) begin
                        cal_state <= ccs_pkg::CAL_COLLECT;
                        cal_first <= 1'b1;
                    end
                end
                ccs_pkg::CAL_COLLECT: begin
                    if (!cfg.cal_en) begin
                        cal_state <= ccs_pkg::CAL_SCORE;
                    end else if (sample_valid) begin
                        cal_first <= 1'b0;
                        min_x <= (cal_first || mag_x < min_x) ? mag_x : min_x;
                        max_x <= (cal_first || mag_x > max_x) ? mag_x : max_x;
                        min_y <= (cal_first || mag_y < min_y) ? mag_y : min_y;
                        max_y <= (cal_first || mag_y > max_y) ? mag_y : max_y;
                        tilt_peak <= (cal_first || tilt_abs > tilt_peak) ? tilt_abs : tilt_peak;
                    end
                end
                ccs_pkg::CAL_SCORE: begin
                    cal_state <= ccs_pkg::CAL_IDLE;
                    ev_cal_done <= 1'b1;
                    // A run with no samples leaves coefficients and score untouched.
                    if (!cal_first) begin
                        cal_off_x <= 16'(($signed({max_x[15], max_x}) + $signed({min_x[15], min_x})) >>> 1);
                        cal_off_y <= 16'(($signed({max_y[15], max_y}) + $signed({min_y[15], min_y})) >>> 1);
                        score.h <= cap_score(span_diff);
                        score.v <= cap_score({1'b0, tilt_peak});
                        score.m <= (span_sum[16:1] == 16'h0) ? ccs_pkg::MAG_MIN : span_sum[16:1];
                    end
                end
                default: cal_state <= ccs_pkg::CAL_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_depth_range: assert property (cfg.depth >= 4'h1 && cfg.depth <= 4'h8)
        else $error("damping depth left its range");
    a_reject_keeps: assert property (wr && paddr == ccs_pkg::ADDR_DEPTH && pwdata == 32'h0
        |=> $stable(cfg.depth) && ev_reject ##1 status[ccs_pkg::ST_REJECT])
        else $error("bad depth write was not refused");
    a_clip_bound: assert property (sample_valid && tilt_raw > $signed(cfg.clip) && $stable(cfg.clip)
        |=> tilt_clipped && tilt_out == $signed($past(cfg.clip)))
        else $error("tilt not clipped to limit");
    a_decl_magnetic: assert property (sample_valid && !module_has_cpu && !cfg.north_true
        && $signed({2'b00, heading_raw}) < circle |=> s1_heading == $past(heading_raw))
        else $error("declination applied under magnetic north");
    a_decl_range: assert property (decl_ok(cfg.decl, 1'b1))
        else $error("declination outside its limit");
    a_cal_start: assert property (cal_state == ccs_pkg::CAL_IDLE && cfg.cal_en
        |=> cal_state == ccs_pkg::CAL_COLLECT)
        else $error("calibration did not start");
    a_cal_stop: assert property (cal_state == ccs_pkg::CAL_COLLECT && !cfg.cal_en
        |=> cal_state == ccs_pkg::CAL_SCORE ##1 cal_state == ccs_pkg::CAL_IDLE && ev_cal_done
        ##1 status[ccs_pkg::ST_CAL_DONE])
        else $error("calibration did not stop and score");
    a_score_range: assert property (score.h <= 4'h9 && score.v <= 4'h9 && score.m != 16'h0)
        else $error("calibration score out of range");
    a_order_swap: assert property (module_has_cpu && !cfg.order_big
        |=> mod_tx_word == swap32($past(host_tx_word)))
        else $error("little endian word not swapped");
    a_save_hold: assert property (save_req && !save_ack |=> save_req)
        else $error("save request dropped before acknowledge");
endmodule

// [tb/ccs_sensor_model.sv]
// Behavioural model of the attached magnetometer module: sample source and save handshake.
`timescale 1ns/1ps
module ccs_sensor_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [63:0] vals,
    input wire logic save_req,
    output logic sample_valid,
    output logic [63:0] bus,
    output logic save_ack
);
    int cnt;
    // Between samples the lines toggle, so stale data is never mistaken for a fresh sample.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_valid <= 1'b0;
            bus <= 64'h0;
            save_ack <= 1'b0;
            cnt <= 0;
        end else begin
            sample_valid <= fire;
            bus <= fire ? vals : ~bus;
            cnt <= (save_req && !save_ack) ? cnt + 1 : 0;
            save_ack <= save_req && !save_ack && cnt >= ACK_DLY;
        end
    end
endmodule

// [tb/test_ccs_top.sv]
// Self-checking testbench for the compass command block.
`timescale 1ns/1ps
module test_ccs_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, cpu = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, htx = 32'h0, rd, prdata, mtx, hpw, ex;
    logic [63:0] vals = 64'h0, sbus;
    logic pready, pslverr, err, sample_valid, heading_valid, tilt_clipped, cal_active, save_req, save_ack, irq;
    logic [2:0] cps;
    logic [15:0] cox, coy;
    ccs_pkg::ccs_cfg_t cfg_seen;
    int bad_count = 0, comparisons = 0, seed = 87, ctrl, d, r;
    always #12.5 pclk = ~pclk;
    ccs_sensor_model u_mod (.pclk(pclk), .presetn(presetn), .fire(fire), .vals(vals), .save_req(save_req),
        .sample_valid(sample_valid), .bus(sbus), .save_ack(save_ack));
    ccs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .heading_raw(sbus[63:48]), .tilt_raw(sbus[47:32]), .mag_x(sbus[31:16]),
        .mag_y(sbus[15:0]), .module_has_cpu(cpu), .host_tx_word(htx), .mod_tx_word(mtx), .mod_rx_word(htx),
        .host_param_word(hpw), .heading_out(), .heading_valid(heading_valid), .tilt_out(),
        .tilt_clipped(tilt_clipped), .conversion_period_select(cps), .settings(cfg_seen), .cal_off_x(cox),
        .cal_off_y(coy), .cal_active(cal_active), .save_req(save_req), .save_ack(save_ack), .irq(irq));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle after a write so status bits that land two edges later are settled.
        if (w) repeat (2) @(posedge pclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic smp(input logic [63:0] v);
        @(posedge pclk);
        fire <= 1'b1;
        vals <= v;
        @(posedge pclk);
        fire <= 1'b0;
        for (int i = 0; i < 8 && heading_valid !== 1'b1; i++) @(posedge pclk);
        chk(heading_valid, 1'b1);
        repeat (2) @(posedge pclk);
    endtask
    function automatic logic [31:0] ehead(int raw, int dc, int tn, int ml);
        int c;
        int v;
        c = ml ? 6400 : 360;
        v = raw + (tn ? dc : 0);
        if (v < 0) v += c;
        if (v >= c) v -= c;
        return 32'(v);
    endfunction
    task automatic results();
        $display("Counts: %0d compared, %0d mismatched", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        results();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(8'h00, 32'h10);
        rchk(8'h04, 32'h1);
        rchk(8'h08, 32'h0);
        rchk(8'h0c, 32'h0);
        rchk(8'h14, 32'h1);
        apb(1'b0, 8'h28, 32'h0);
        chk(err, 1'b1);
        $display("reset values done");
        apb(1'b1, 8'h24, 32'hf);
        d = 1;
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 0 : (i == 1) ? 8 : {$random(seed)} % 10;
            if (r >= 1 && r <= 8) d = r;
            apb(1'b1, 8'h04, r);
            rchk(8'h04, d);
            if (i == 0) chk(irq, 1'b1);
            apb(1'b1, 8'h20, 32'hf);
            chk(irq, 1'b0);
        end
        apb(1'b1, 8'h10, 32'h5);
        apb(1'b1, 8'h10, 32'h8);
        chk(cps, 3'h5);
        $display("range tests done");
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 10 : {$random(seed)} % 360;
            d = (i == 0) ? -180 : $random(seed) % 181;
            ctrl = i[0] ? 16 : 18;
            apb(1'b1, 8'h00, ctrl);
            apb(1'b1, 8'h0c, d);
            smp({16'(r), 48'h0});
            rchk(8'h18, ehead(r, d, !i[0], 0));
        end
        apb(1'b1, 8'h00, 32'h16);
        apb(1'b1, 8'h0c, 32'd3201);
        rchk(8'h0c, d);
        apb(1'b1, 8'h0c, -3200);
        smp({16'd100, 48'h0});
        rchk(8'h18, ehead(100, -3200, 1, 1));
        cpu <= 1'b1;
        smp({16'd100, 48'h0});
        rchk(8'h18, 32'd100);
        $display("heading tests done");
        for (int i = 0; i < 4; i++) begin
            cpu <= i[1];
            apb(1'b1, 8'h00, i[0] ? 32'h10 : 32'h0);
            htx <= $random(seed);
            repeat (3) @(posedge pclk);
            ex = (i == 2) ? {htx[7:0], htx[15:8], htx[23:16], htx[31:24]} : htx;
            chk(mtx, ex);
            chk(hpw, ex);
        end
        cpu <= 1'b0;
        apb(1'b1, 8'h08, 32'd901);
        rchk(8'h08, 32'h0);
        apb(1'b1, 8'h08, 32'd30);
        smp({16'h0, 16'hffce, 32'h0});
        chk(tilt_clipped, 1'b1);
        rchk(8'h1c, 32'h1ffe2);
        smp({16'h0, 16'h0014, 32'h0});
        rchk(8'h1c, 32'h14);
        smp({16'h0, 16'h0032, 32'h0});
        rchk(8'h1c, 32'h1001e);
        chk(cfg_seen.clip, 32'h1e);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h00, 32'h11);
        for (int i = 0; i < 2; i++) begin
            smp({16'd100, 48'h0});
            rchk(8'h18, i ? 32'd75 : 32'd50);
        end
        $display("order and clip tests done");
        apb(1'b1, 8'h00, 32'h18);
        chk(cal_active, 1'b1);
        smp({32'h0, 16'hffe0, 16'hfff0});
        smp({16'h0, 16'h0050, 16'h0040, 16'h0010});
        apb(1'b1, 8'h00, 32'h10);
        chk(cal_active, 1'b0);
        rchk(8'h14, 32'h00450040);
        chk({cox, coy}, 32'h00100000);
        apb(1'b1, 8'h00, 32'h30);
        chk(save_req, 1'b1);
        for (int i = 0; i < 20 && save_req !== 1'b0; i++) @(posedge pclk);
        chk(save_req, 1'b0);
        repeat (2) @(posedge pclk);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd[2:1], 2'h3);
        $display("calibration and save tests done");
        results();
    end
endmodule
